// *** inc/mfo_pkg.sv ***
package mfo_pkg;

  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MAXLEN = 8'h04;
  localparam logic [7:0] OFS_TX_STAT = 8'h08;
  localparam logic [7:0] OFS_RX_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_EN = 8'h14;
  localparam logic [7:0] OFS_INT_CLR = 8'h18;

  // ==========================================================
  // Control register fields and reset values.
  localparam int CB_DUPLEX = 0;
  localparam int CB_LENCHK = 1;
  localparam int CB_HUGE = 2;
  localparam int CB_HDR = 3;
  localparam int CB_CRCEN = 4;
  localparam int CB_PAD_LO = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] MAXLEN_RST = 16'h05EE;
  localparam logic [2:0] PAD_TO_60 = 3'h1;
  localparam logic [2:0] PAD_NONE = 3'h2;
  localparam logic [2:0] PAD_TO_64 = 3'h3;

  // ==========================================================
  // Interrupt bit positions.
  localparam int IB_TX_DONE = 0;
  localparam int IB_TX_ERR = 1;
  localparam int IB_RX_DONE = 2;
  localparam int IB_RX_ERR = 3;

  // ==========================================================
  // Frame constants and counts.
  localparam logic [15:0] PAD_LEN_60 = 16'h003C;
  localparam logic [15:0] PAD_LEN_64 = 16'h0040;
  localparam logic [15:0] HDR_BYTES = 16'h0004;
  localparam logic [15:0] FCS_BYTES = 16'h0004;
  localparam logic [15:0] MAC_HDR_BYTES = 16'h000E;
  localparam logic [15:0] LEN_FIELD_OFS = 16'h000C;
  localparam logic [15:0] LEN_MAX = 16'h05DC;
  localparam logic [15:0] LEN_NONE = 16'hFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  typedef enum logic [2:0] {
    T_DATA = 3'b001,
    T_PAD = 3'b010,
    T_FCS = 3'b100
  } mfo_tx_state_type;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] maxlen;
    mfo_tx_state_type tstate;
    logic [15:0] tcnt;
    logic [15:0] tpad;
    logic [31:0] tcrc;
    logic [15:0] tlen;
    logic tdrop;
    logic tappend;
    logic tlenbad;
    logic [1:0] fidx;
    logic [31:0] tstat;
    logic tx_ready;
    logic tx_out_valid;
    logic [7:0] tx_out_data;
    logic tx_out_last;
    logic tx_out_abort;
    logic [15:0] rcnt;
    logic [31:0] rcrc;
    logic [15:0] rlen;
    logic rdrop;
    logic [31:0] rstat;
    logic rx_out_valid;
    logic [7:0] rx_out_data;
    logic rx_out_last;
    logic rx_out_abort;
    logic [3:0] ist;
    logic [3:0] ien;
    logic irq;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } mfo_state_type;

endpackage

// *** hw/mfo_frame_option.sv ***
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module mfo_frame_option
  import mfo_pkg::*;
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Transmit bytes from the packet buffer.
  input wire logic tx_in_valid,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_last,
  output logic tx_in_ready,
  // Transmit bytes toward the PHY.
  output logic tx_out_valid,
  output logic [7:0] tx_out_data,
  output logic tx_out_last,
  output logic tx_out_abort,
  // Receive bytes from the PHY.
  input wire logic rx_in_valid,
  input wire logic [7:0] rx_in_data,
  input wire logic rx_in_last,
  // Receive bytes toward the packet buffer.
  output logic rx_out_valid,
  output logic [7:0] rx_out_data,
  output logic rx_out_last,
  output logic rx_out_abort,
  // Mode and interrupt.
  output logic mac_full_duplex_select,
  output logic irq
);

  // ==========================================================
  // Helpers.
  function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // True when the field holds a length that disagrees with the size.
  function automatic logic len_bad(logic en, logic [15:0] fld,
                                   logic [15:0] cnt, logic [15:0] ovh);
    return en && (fld <= LEN_MAX) && (fld != 16'(cnt - ovh));
  endfunction

  function automatic logic reg_hit(logic [7:0] a);
    return a == OFS_CTRL || a == OFS_MAXLEN || a == OFS_TX_STAT ||
           a == OFS_RX_STAT || a == OFS_INT_STAT || a == OFS_INT_EN ||
           a == OFS_INT_CLR;
  endfunction

  mfo_state_type s_r;
  mfo_state_type s_nxt;

  // ==========================================================
  // Next state.
  always_comb begin
    logic hdr_en;
    logic allow;
    logic lchk;
    logic [2:0] pad;
    logic [15:0] lofs;
    logic [15:0] t1;
    logic [15:0] r1;
    logic [15:0] ovh;
    logic [3:0] ev;
    logic [3:0] clr;
    logic wr;
    logic tfin;
    logic tbad;
    logic rbad;
    hdr_en = s_r.ctrl[CB_HDR];
    allow = s_r.ctrl[CB_HUGE];
    lchk = s_r.ctrl[CB_LENCHK];
    pad = s_r.ctrl[7:CB_PAD_LO];
    lofs = hdr_en ? 16'(LEN_FIELD_OFS + HDR_BYTES) : LEN_FIELD_OFS;
    t1 = 16'(s_r.tcnt + 16'h0001);
    r1 = 16'(s_r.rcnt + 16'h0001);
    ovh = 16'(MAC_HDR_BYTES + (hdr_en ? HDR_BYTES : 16'h0000));
    ev = 4'h0;
    clr = 4'h0;
    tfin = 1'b0;
    tbad = 1'b0;
    rbad = 1'b0;
    wr = psel && penable && s_r.pready && pwrite;
    s_nxt = s_r;
    s_nxt.tx_out_valid = 1'b0;
    s_nxt.tx_out_last = 1'b0;
    s_nxt.tx_out_abort = 1'b0;
    s_nxt.rx_out_valid = 1'b0;
    s_nxt.rx_out_last = 1'b0;
    s_nxt.rx_out_abort = 1'b0;

    // Transmit path.
    unique case (s_r.tstate)
      T_DATA: begin
        if (tx_in_valid && s_r.tx_ready) begin
          s_nxt.tcnt = t1;
          if (!(hdr_en && s_r.tcnt < HDR_BYTES)) begin
            s_nxt.tcrc = crc_byte(s_r.tcrc, tx_in_data);
          end
          if (s_r.tcnt == lofs) begin
            s_nxt.tlen[15:8] = tx_in_data;
          end
          if (s_r.tcnt == 16'(lofs + 16'h0001)) begin
            s_nxt.tlen[7:0] = tx_in_data;
          end
          if (!allow && t1 > s_r.maxlen && !s_r.tdrop) begin
            s_nxt.tdrop = 1'b1;
            s_nxt.tx_out_abort = 1'b1;
          end
          if (!s_nxt.tdrop) begin
            s_nxt.tx_out_valid = 1'b1;
            s_nxt.tx_out_data = tx_in_data;
          end
          if (tx_in_last) begin
            s_nxt.tappend = s_r.ctrl[CB_CRCEN] || pad == PAD_TO_60 ||
                            pad == PAD_TO_64;
            s_nxt.tpad = (pad == PAD_TO_64) ? PAD_LEN_64 :
                         (pad == PAD_TO_60) ? PAD_LEN_60 : 16'h0000;
            s_nxt.tlenbad = len_bad(lchk, s_nxt.tlen, t1,
                16'(ovh + (s_nxt.tappend ? 16'h0000 : FCS_BYTES)));
            if (s_nxt.tdrop) begin
              tfin = 1'b1;
            end else if (t1 < s_nxt.tpad) begin
              s_nxt.tstate = T_PAD;
            end else if (s_nxt.tappend) begin
              s_nxt.tstate = T_FCS;
            end else begin
              s_nxt.tx_out_last = 1'b1;
              tfin = 1'b1;
            end
          end
        end
      end
      T_PAD: begin
        s_nxt.tcnt = t1;
        s_nxt.tcrc = crc_byte(s_r.tcrc, 8'h00);
        s_nxt.tx_out_valid = 1'b1;
        s_nxt.tx_out_data = 8'h00;
        if (t1 == s_r.tpad) begin
          s_nxt.tstate = T_FCS;
        end
      end
      T_FCS: begin
        s_nxt.tx_out_valid = 1'b1;
        s_nxt.tx_out_data = ~s_r.tcrc[{s_r.fidx, 3'b000} +: 8];
        s_nxt.fidx = 2'(s_r.fidx + 2'b01);
        if (s_r.fidx == 2'b11) begin
          s_nxt.tx_out_last = 1'b1;
          tfin = 1'b1;
        end
      end
      default: begin
        s_nxt.tstate = T_DATA;
      end
    endcase

    if (tfin) begin
      // Without append the CRC ran over the caller's FCS too.
      tbad = !s_nxt.tappend && s_nxt.tcrc != CRC_RESIDUE;
      s_nxt.tstat = {s_nxt.tcnt, 13'h0000, s_nxt.tdrop, s_nxt.tlenbad,
                     tbad};
      ev[IB_TX_DONE] = 1'b1;
      ev[IB_TX_ERR] = tbad || s_nxt.tdrop || s_nxt.tlenbad;
      s_nxt.tstate = T_DATA;
      s_nxt.tcnt = 16'h0000;
      s_nxt.tcrc = CRC_INIT;
      s_nxt.tlen = LEN_NONE;
      s_nxt.tdrop = 1'b0;
      s_nxt.fidx = 2'b00;
    end
    s_nxt.tx_ready = (s_nxt.tstate == T_DATA);

    // Receive path.
    if (rx_in_valid) begin
      s_nxt.rcnt = r1;
      if (!(hdr_en && s_r.rcnt < HDR_BYTES)) begin
        s_nxt.rcrc = crc_byte(s_r.rcrc, rx_in_data);
      end
      if (s_r.rcnt == lofs) begin
        s_nxt.rlen[15:8] = rx_in_data;
      end
      if (s_r.rcnt == 16'(lofs + 16'h0001)) begin
        s_nxt.rlen[7:0] = rx_in_data;
      end
      if (!allow && r1 > s_r.maxlen && !s_r.rdrop) begin
        s_nxt.rdrop = 1'b1;
        s_nxt.rx_out_abort = 1'b1;
      end
      if (!s_nxt.rdrop) begin
        s_nxt.rx_out_valid = 1'b1;
        s_nxt.rx_out_data = rx_in_data;
        s_nxt.rx_out_last = rx_in_last;
      end
      if (rx_in_last) begin
        rbad = s_nxt.rcrc != CRC_RESIDUE;
        s_nxt.rstat = {r1, 13'h0000, s_nxt.rdrop,
            len_bad(lchk, s_nxt.rlen, r1, 16'(ovh + FCS_BYTES)),
            rbad};
        ev[IB_RX_DONE] = 1'b1;
        ev[IB_RX_ERR] = rbad || s_nxt.rdrop || s_nxt.rstat[1];
        s_nxt.rcnt = 16'h0000;
        s_nxt.rcrc = CRC_INIT;
        s_nxt.rlen = LEN_NONE;
        s_nxt.rdrop = 1'b0;
      end
    end

    // Register writes take effect at the completing edge.
    if (wr) begin
      unique case (paddr)
        OFS_CTRL: s_nxt.ctrl = pwdata[7:0];
        OFS_MAXLEN: s_nxt.maxlen = pwdata[15:0];
        OFS_INT_EN: s_nxt.ien = pwdata[3:0];
        OFS_INT_CLR: clr = pwdata[3:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    s_nxt.ist = (s_r.ist & ~clr) | ev;
    s_nxt.irq = |(s_nxt.ist & s_nxt.ien);

    // APB answers one cycle into the access phase.
    s_nxt.pready = psel && penable && !s_r.pready;
    s_nxt.pslverr = s_nxt.pready && !reg_hit(paddr);
    s_nxt.prdata = 32'h00000000;
    if (s_nxt.pready && !pwrite) begin
      unique case (paddr)
        OFS_CTRL: s_nxt.prdata = {24'h000000, s_r.ctrl};
        OFS_MAXLEN: s_nxt.prdata = {16'h0000, s_r.maxlen};
        OFS_TX_STAT: s_nxt.prdata = s_r.tstat;
        OFS_RX_STAT: s_nxt.prdata = s_r.rstat;
        OFS_INT_STAT: s_nxt.prdata = {28'h0000000, s_r.ist};
        OFS_INT_EN: s_nxt.prdata = {28'h0000000, s_r.ien};
        default: s_nxt.prdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.maxlen <= MAXLEN_RST;
      s_r.tstate <= T_DATA;
      s_r.tcrc <= CRC_INIT;
      s_r.rcrc <= CRC_INIT;
      s_r.tlen <= LEN_NONE;
      s_r.rlen <= LEN_NONE;
      s_r.tx_ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready = s_r.pready;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign tx_in_ready = s_r.tx_ready;
  assign tx_out_valid = s_r.tx_out_valid;
  assign tx_out_data = s_r.tx_out_data;
  assign tx_out_last = s_r.tx_out_last;
  assign tx_out_abort = s_r.tx_out_abort;
  assign rx_out_valid = s_r.rx_out_valid;
  assign rx_out_data = s_r.rx_out_data;
  assign rx_out_last = s_r.rx_out_last;
  assign rx_out_abort = s_r.rx_out_abort;
  assign mac_full_duplex_select = s_r.ctrl[CB_DUPLEX];
  assign irq = s_r.irq;

endmodule

// *** bench/mfo_properties.sv ***
`timescale 1ns/100ps
module mfo_properties
  import mfo_pkg::*;
(
  // Clock, reset and APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Transmit stream and mode.
  input wire logic tx_in_valid,
  input wire logic tx_in_ready,
  input wire logic tx_out_valid,
  input wire logic tx_out_last,
  input wire logic tx_out_abort,
  input wire logic mac_full_duplex_select
);
  // ========
  // Slave timing and transmit stream checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable && !$past(penable); endsequence
  sequence s_ans; !pready ##1 pready ##1 !pready; endsequence
  chk_apb_wait: assert property (s_acc |-> s_ans)
    else $error("access length wrong");
  chk_ready_owner: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_unmapped_err: assert property (
    pready && paddr > OFS_INT_CLR |-> pslverr)
    else $error("no error on unmapped address");
  chk_pad_stall: assert property (
    tx_out_valid && !tx_out_last && !$past(tx_in_valid && tx_in_ready)
    |-> !tx_in_ready)
    else $error("input taken during pad or check bytes");
  chk_ready_return: assert property (tx_out_last |=> tx_in_ready)
    else $error("input not ready after frame end");
  chk_abort_pulse: assert property (
    tx_out_abort |=> !tx_out_abort && !tx_out_valid)
    else $error("abort not single or bytes forwarded");
  chk_duplex_write: assert property ($changed(mac_full_duplex_select)
    |-> $past(pready && paddr == OFS_CTRL))
    else $error("duplex changed without control write");
endmodule
bind mfo_frame_option mfo_properties u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .tx_in_valid(tx_in_valid),
  .tx_in_ready(tx_in_ready), .tx_out_valid(tx_out_valid),
  .tx_out_last(tx_out_last), .tx_out_abort(tx_out_abort),
  .mac_full_duplex_select(mac_full_duplex_select));

// *** bench/mfo_phy_model.sv ***
`timescale 1ns/100ps
module mfo_phy_model
  import mfo_pkg::*;
(
  // Bytes from the MAC.
  input wire logic pclk,
  input wire logic tx_out_valid,
  input wire logic tx_out_last,
  input wire logic tx_out_abort,
  // Bytes toward the MAC.
  output logic rx_in_valid,
  output logic [7:0] rx_in_data,
  output logic rx_in_last
);
  int tx_cnt = 0;
  int tx_len = 0;
  logic tx_done = 1'b0;
  logic tx_abt = 1'b0;
  // ========
  // Frame bytes count up, with the length field at bytes 12 and 13.
  function automatic logic [7:0] fbyte(input int i, input logic [7:0] lv);
    return (i == 12) ? 8'h00 : (i == 13) ? lv : 8'(i + 1);
  endfunction
  always @(posedge pclk) begin
    if (tx_out_valid) begin
      tx_cnt <= tx_cnt + 1;
    end
    if (tx_out_last || tx_out_abort) begin
      tx_cnt <= 0;
      tx_len <= tx_cnt + int'(tx_out_valid);
      tx_abt <= tx_out_abort;
      tx_done <= 1'b1;
    end
  end
  initial begin
    rx_in_valid = 1'b0;
    rx_in_data = 8'h00;
    rx_in_last = 1'b0;
  end
  // The check word covers bytes from skip on and goes low byte first.
  task automatic send(input int n, input int skip);
    logic [31:0] c;
    logic [7:0] b;
    c = CRC_INIT;
    for (int i = 0; i < n + 4; i++) begin
      b = (i < n) ? fbyte(i, 8'h00) : 8'(~c >> (8 * (i - n)));
      if (i >= skip && i < n) begin
        c = c ^ {24'h0, b};
        repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      @(posedge pclk);
      rx_in_valid <= 1'b1;
      rx_in_data <= b;
      rx_in_last <= (i == n + 3);
    end
    @(posedge pclk);
    rx_in_valid <= 1'b0;
    rx_in_last <= 1'b0;
    rx_in_data <= ~b;
  endtask
endmodule

// *** bench/tb_mac_frame_option_control.sv ***
`timescale 1ns/100ps
module tb_mac_frame_option_control
  import mfo_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic tx_in_valid = 1'b0, tx_in_last = 1'b0;
  logic [7:0] paddr = 8'h00, tx_in_data = 8'h00, rx_in_data;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tx_in_ready, tx_out_valid, tx_out_last;
  logic tx_out_abort, rx_in_valid, rx_in_last, dup, irq, er;
  logic rxv;
  int rx_n = 0;
  int err_total = 0;
  int num_checks = 0;
  // Status, control, frame length, length field, bytes out.
  logic [35:0] trow [9] = '{36'h0240A0040, 36'h0640A0044, 36'h0540A000E,
    36'h1440A000A, 36'h4501E0000, 36'h0541E0022, 36'h056140618,
    36'h256140718, 36'h055140718};
  mfo_frame_option DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
    .tx_in_last(tx_in_last), .tx_in_ready(tx_in_ready),
    .tx_out_valid(tx_out_valid), .tx_out_data(), .tx_out_last(tx_out_last),
    .tx_out_abort(tx_out_abort), .rx_in_valid(rx_in_valid),
    .rx_in_data(rx_in_data), .rx_in_last(rx_in_last), .rx_out_valid(rxv),
    .rx_out_data(), .rx_out_last(), .rx_out_abort(),
    .mac_full_duplex_select(dup), .irq(irq));
  mfo_phy_model phy (.pclk(pclk), .tx_out_valid(tx_out_valid),
    .tx_out_last(tx_out_last), .tx_out_abort(tx_out_abort),
    .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
    .rx_in_last(rx_in_last));
  // Counts bytes echoed toward the packet buffer.
  always @(posedge pclk) begin
    if (rxv) begin
      rx_n <= rx_n + 1;
    end
  end
  // ========
  // Bus, stream and compare tasks.
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tx(input logic [7:0] n, input logic [7:0] lv);
    phy.tx_done = 1'b0;
    for (int i = 0; i < n; i++) begin
      tx_in_valid <= 1'b1;
      tx_in_data <= phy.fbyte(i, lv);
      tx_in_last <= (i == n - 1);
      do @(negedge pclk); while (tx_in_ready !== 1'h1);
      @(posedge pclk);
    end
    tx_in_valid <= 1'b0;
    tx_in_last <= 1'b0;
    tx_in_data <= ~tx_in_data;
    for (int k = 0; k < 300 && !phy.tx_done; k++) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ========
  // Test sequence, clock and watchdog.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'h0, OFS_CTRL, 32'h0);
    chk("ctrl reset", {24'h0, CTRL_RST}, rd);
    apb(1'h0, OFS_MAXLEN, 32'h0);
    chk("maxlen reset", {16'h0, MAXLEN_RST}, rd);
    apb(1'h0, 8'h1C, 32'h0);
    chk("unmapped error", 1'h1, er);
    apb(1'h1, OFS_MAXLEN, 32'h14);
    apb(1'h1, OFS_INT_EN, 32'hF);
    for (int k = 0; k < 9; k++) begin
      apb(1'h1, OFS_CTRL, {24'h0, trow[k][31:24]});
      tx(trow[k][23:16], trow[k][15:8]);
      if (!trow[k][34]) begin
        chk("tx bytes", trow[k][7:0], phy.tx_len);
      end
      chk("tx abort", trow[k][34], phy.tx_abt);
      apb(1'h0, OFS_TX_STAT, 32'h0);
      chk("tx status", trow[k][34:32], rd[2:0]);
      chk("duplex", trow[k][24], dup);
    end
    chk("irq set", 1'h1, irq);
    apb(1'h1, OFS_INT_CLR, 32'hF);
    apb(1'h1, OFS_INT_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 1'h0, irq);
    for (int k = 0; k < 3; k++) begin
      apb(1'h1, OFS_CTRL, {24'h0, (k == 0) ? 8'h0C : 8'h04});
      rx_n = 0;
      phy.send(20, (k == 2) ? 0 : 4);
      repeat (2) @(posedge pclk);
      chk("rx bytes out", 32'd24, rx_n);
      apb(1'h0, OFS_RX_STAT, 32'h0);
      chk("rx crc bad", k == 1, rd[0]);
    end
    chk("irq masked", 1'h0, irq);
    apb(1'h0, OFS_INT_STAT, 32'h0);
    chk("rx done event", 1'h1, rd[IB_RX_DONE]);
    apb(1'h1, OFS_INT_EN, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq enabled", 1'h1, irq);
    report_and_stop();
  end
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule
